// ==== hw/pts_pkg.sv ====
// Constants and types shared by the pulse time-stamp filter block
package pts_pkg;
	// ----------------------------------------------------------------
	// Clock and time base
	// ----------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int NS_PER_SEC = 1_000_000_000;
	localparam int SEC_PER_WEEK = 604800;
	localparam int WEEK_W = 16;
	localparam int SEC_W = 20;
	localparam int NS_W = 30;
	localparam int STAMP_W = WEEK_W + SEC_W + NS_W;
	localparam int ENTRY_W = STAMP_W + 1;
	// ----------------------------------------------------------------
	// Filter figures
	// ----------------------------------------------------------------
	localparam int REL_WINDOW_NS = 500;
	localparam int MIN_SPACING_NS = 500;
	localparam int MIN_SPACING_CYC = (MIN_SPACING_NS + CLK_NS - 1) / CLK_NS;
	localparam int SPACE_CNT_W = 4;
	localparam int LIMIT_W = 7;
	localparam int PERIOD_W = 20;
	localparam logic [LIMIT_W-1:0] LIMIT_MIN = 7'h01;
	localparam logic [LIMIT_W-1:0] LIMIT_MAX = 7'h64;
	localparam logic [PERIOD_W-1:0] PERIOD_MIN = 20'h0_0001;
	localparam logic [PERIOD_W-1:0] PERIOD_MAX = 20'h9_3A80;
	localparam int AVG_SHIFT = 3;
	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	localparam int MEM_DEPTH = 100;
	localparam int FIFO_DEPTH = 8;
	// Filter set bit positions
	localparam int FLT_OFF = 0;
	localparam int FLT_REL = 1;
	localparam int FLT_DUR = 2;
	localparam int FLT_RATE = 3;
	localparam logic [3:0] FILTER_RESET = 4'h1;
	localparam logic SRC_GPS = 1'b0;
	localparam logic SRC_EXT = 1'b1;
	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {PTS_MODE_OFF, PTS_MODE_ASYNC, PTS_MODE_MEMORY,
		PTS_MODE_OUTPUT, PTS_MODE_OFFSET_REPORT_SELECT} pts_mode_t;
	typedef enum logic [1:0] {PTS_SRC_GPS, PTS_SRC_EXT, PTS_SRC_ALL} pts_src_t;
	typedef enum logic [1:0] {PTS_DIFF_EXT, PTS_DIFF_GPS, PTS_DIFF_ALL} pts_diff_t;
endpackage

// ==== hw/pts_fifo.sv ====
// Parameterised valid/ready FIFO held in flip-flops
`timescale 1ns/10ps
module pts_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

	generate
		if (WIDTH < 1 || DEPTH < 2) begin : g_bad
			$error("pts_fifo: WIDTH must be >= 1 and DEPTH >= 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] rd_reg;
	logic [PW-1:0] wr_reg;
	logic [PW:0] cnt_reg;
	logic push;
	logic pop;

	assign in_ready = (cnt_reg != DEPTH_C);
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem_reg[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_reg <= '0;
			wr_reg <= '0;
			cnt_reg <= '0;
		end else if (flush) begin
			rd_reg <= '0;
			wr_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == LAST_C) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == LAST_C) ? '0 : rd_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// ==== hw/pts_timestamp_filter.sv ====
// Pulse time-stamp capture, filtering and stamp memory
`timescale 1ns/10ps
module pts_timestamp_filter
	import pts_pkg::*;
#(
	parameter int MEM_ENTRIES = MEM_DEPTH,
	parameter int BUF_DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic gps_pps,
	input wire logic ext_pps,
	input wire logic time_load,
	input wire logic [WEEK_W-1:0] time_load_week,
	input wire logic [SEC_W-1:0] time_load_sec,
	input wire logic mode_wr,
	input wire logic [2:0] mode_data,
	input wire logic source_wr,
	input wire logic [1:0] source_data,
	input wire logic offset_report_select_wr,
	input wire logic [1:0] offset_report_select_data,
	input wire logic filter_wr,
	input wire logic [3:0] filter_data,
	input wire logic per_second_store_limit_wr,
	input wire logic [LIMIT_W-1:0] per_second_store_limit_data,
	input wire logic store_period_seconds_wr,
	input wire logic [PERIOD_W-1:0] store_period_seconds_data,
	input wire logic ext_edge_falling,
	input wire logic stamp_clear,
	input wire logic mem_hold,
	input wire logic [6:0] mem_rd_idx,
	output logic [ENTRY_W-1:0] mem_rd_data,
	output logic [6:0] mem_count,
	output logic [2:0] mode,
	output logic [1:0] source,
	output logic [1:0] offset_report_select,
	output logic [3:0] filter_set,
	output logic [LIMIT_W-1:0] per_second_store_limit,
	output logic [PERIOD_W-1:0] store_period_seconds,
	output logic [ENTRY_W-1:0] last_stamp,
	output logic last_stamp_valid,
	output logic stamp_event,
	output logic offset_ext_valid,
	output logic offset_gps_valid,
	output logic signed [31:0] offset_ext_ns,
	output logic signed [31:0] offset_gps_ns,
	output logic drop_overflow
);
	generate
		if (MEM_ENTRIES < 2 || MEM_ENTRIES > 127 || BUF_DEPTH < 2) begin : g_bad
			$error("pts_timestamp_filter: unsupported memory or buffer depth");
		end
	endgenerate

	localparam int MPW = $clog2(MEM_ENTRIES);
	localparam logic [MPW-1:0] MEM_LAST = MPW'(MEM_ENTRIES - 1);
	localparam logic [6:0] MEM_FULL = 7'(MEM_ENTRIES);
	localparam logic [NS_W-1:0] NS_STEP = NS_W'(CLK_NS);
	localparam logic [NS_W-1:0] NS_TOP = NS_W'(NS_PER_SEC - CLK_NS);
	localparam logic [SEC_W-1:0] SEC_TOP = SEC_W'(SEC_PER_WEEK - 1);
	localparam logic signed [31:0] HALF_SEC = 32'sd500_000_000;
	localparam logic signed [31:0] FULL_SEC = 32'sd1_000_000_000;
	localparam logic signed [31:0] REL_WIN = 32'(REL_WINDOW_NS);
	localparam logic [SPACE_CNT_W-1:0] SPACE_MIN = SPACE_CNT_W'(MIN_SPACING_CYC);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Folds a nanosecond difference into one signed half second
	function automatic logic signed [31:0] wrap_ns(input logic [NS_W-1:0] a,
			input logic [NS_W-1:0] b);
		logic signed [31:0] d;
		d = $signed({2'b00, a}) - $signed({2'b00, b});
		if (d > HALF_SEC) begin
			d = d - FULL_SEC;
		end else if (d < -HALF_SEC) begin
			d = d + FULL_SEC;
		end
		return d;
	endfunction

	function automatic logic [MPW-1:0] mem_step(input logic [MPW-1:0] p);
		return (p == MEM_LAST) ? '0 : p + 1'b1;
	endfunction

	// ----------------------------------------------------------------
	// Configuration
	// ----------------------------------------------------------------
	logic [2:0] mode_reg;
	logic [1:0] source_reg;
	logic [1:0] diff_sel_reg;
	logic [3:0] filter_reg;
	logic [LIMIT_W-1:0] limit_reg;
	logic [PERIOD_W-1:0] period_reg;
	logic rel_en;
	logic dur_en;
	logic rate_en;
	logic gps_on;
	logic ext_on;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg <= PTS_MODE_OFF;
			source_reg <= PTS_SRC_GPS;
			diff_sel_reg <= PTS_DIFF_EXT;
		end else begin
			if (mode_wr && mode_data <= PTS_MODE_OFFSET_REPORT_SELECT) begin
				mode_reg <= mode_data;
			end
			// Offset mode needs both sources stamped
			if (mode_wr && mode_data == PTS_MODE_OFFSET_REPORT_SELECT) begin
				source_reg <= PTS_SRC_ALL;
			end else if (source_wr && source_data <= PTS_SRC_ALL) begin
				source_reg <= source_data;
			end
			if (offset_report_select_wr && offset_report_select_data <= PTS_DIFF_ALL) begin
				diff_sel_reg <= offset_report_select_data;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			filter_reg <= FILTER_RESET;
		end else if (filter_wr) begin
			if (filter_data[FLT_OFF] || filter_data == 4'h0) begin
				filter_reg <= FILTER_RESET;
			end else begin
				filter_reg <= filter_data;
			end
		end
	end

	// Out-of-range writes are ignored and leave both settings alone
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			limit_reg <= LIMIT_MIN;
			period_reg <= PERIOD_MIN;
		end else if (per_second_store_limit_wr
				&& per_second_store_limit_data >= LIMIT_MIN
				&& per_second_store_limit_data <= LIMIT_MAX) begin
			limit_reg <= per_second_store_limit_data;
			period_reg <= PERIOD_MIN;
		end else if (store_period_seconds_wr
				&& store_period_seconds_data >= PERIOD_MIN
				&& store_period_seconds_data <= PERIOD_MAX) begin
			period_reg <= store_period_seconds_data;
			limit_reg <= LIMIT_MIN;
		end
	end

	assign rel_en = filter_reg[FLT_REL];
	assign dur_en = filter_reg[FLT_DUR];
	assign rate_en = filter_reg[FLT_RATE];
	assign gps_on = (source_reg != PTS_SRC_EXT) || rel_en;
	assign ext_on = (source_reg != PTS_SRC_GPS);

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	logic [NS_W-1:0] ns_reg;
	logic [SEC_W-1:0] sec_reg;
	logic [WEEK_W-1:0] week_reg;
	logic sec_tick;

	assign sec_tick = (ns_reg == NS_TOP);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ns_reg <= '0;
			sec_reg <= '0;
			week_reg <= '0;
		end else if (time_load) begin
			ns_reg <= '0;
			sec_reg <= time_load_sec;
			week_reg <= time_load_week;
		end else if (sec_tick) begin
			ns_reg <= '0;
			sec_reg <= (sec_reg == SEC_TOP) ? '0 : sec_reg + 1'b1;
			week_reg <= (sec_reg == SEC_TOP) ? week_reg + 1'b1 : week_reg;
		end else begin
			ns_reg <= ns_reg + NS_STEP;
		end
	end

	// ----------------------------------------------------------------
	// Edge capture
	// ----------------------------------------------------------------
	logic gps_prev_reg;
	logic ext_prev_reg;
	logic gps_edge;
	logic ext_edge;
	logic ext_pend_reg;
	logic [STAMP_W-1:0] ext_pend_stamp_reg;
	logic [STAMP_W-1:0] now_stamp;
	logic cand_v;
	logic cand_src;
	logic [STAMP_W-1:0] cand_stamp;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gps_prev_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end else begin
			gps_prev_reg <= gps_pps;
			ext_prev_reg <= ext_pps;
		end
	end

	assign now_stamp = {week_reg, sec_reg, ns_reg};
	assign gps_edge = gps_pps && !gps_prev_reg && gps_on;
	assign ext_edge = ext_on && (ext_edge_falling ? (!ext_pps && ext_prev_reg)
		: (ext_pps && !ext_prev_reg));

	// Coincident pulses: GPS goes first, the external stamp waits one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_pend_reg <= 1'b0;
			ext_pend_stamp_reg <= '0;
		end else begin
			ext_pend_reg <= ext_edge && gps_edge;
			if (ext_edge) begin
				ext_pend_stamp_reg <= now_stamp;
			end
		end
	end

	always_comb begin
		cand_v = 1'b0;
		cand_src = SRC_GPS;
		cand_stamp = now_stamp;
		if (mode_reg != PTS_MODE_OFF && !stamp_clear) begin
			if (gps_edge) begin
				cand_v = 1'b1;
			end else if (ext_pend_reg) begin
				cand_v = 1'b1;
				cand_src = SRC_EXT;
				cand_stamp = ext_pend_stamp_reg;
			end else if (ext_edge) begin
				cand_v = 1'b1;
				cand_src = SRC_EXT;
			end
		end
	end

	// ----------------------------------------------------------------
	// Filters
	// ----------------------------------------------------------------
	logic [NS_W-1:0] gps_avg_reg;
	logic gps_avg_ok_reg;
	logic [SPACE_CNT_W-1:0] space_cnt_reg [2];
	logic signed [31:0] rel_diff;
	logic signed [31:0] gps_sec_off;
	logic rel_ok;
	logic dur_ok;
	logic rate_ok;
	logic buf_ready;
	logic accept;
	logic [LIMIT_W-1:0] win_cnt_reg;
	logic [PERIOD_W-1:0] win_sec_reg;

	assign rel_diff = wrap_ns(cand_stamp[NS_W-1:0], gps_avg_reg);
	assign gps_sec_off = wrap_ns(cand_stamp[NS_W-1:0], '0);
	// No average yet: window cannot judge, so the pulse passes
	assign rel_ok = !gps_avg_ok_reg || (rel_diff <= REL_WIN && rel_diff >= -REL_WIN);
	assign dur_ok = (space_cnt_reg[cand_src] >= SPACE_MIN);
	assign rate_ok = (win_cnt_reg < limit_reg);
	assign accept = cand_v && buf_ready && (!rel_en || rel_ok)
		&& (!dur_en || dur_ok) && (!rate_en || rate_ok);

	// Running average of the GPS pulse position in the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gps_avg_reg <= '0;
			gps_avg_ok_reg <= 1'b0;
		end else if (stamp_clear) begin
			gps_avg_reg <= '0;
			gps_avg_ok_reg <= 1'b0;
		end else if (cand_v && cand_src == SRC_GPS) begin
			gps_avg_ok_reg <= 1'b1;
			if (!gps_avg_ok_reg) begin
				gps_avg_reg <= cand_stamp[NS_W-1:0];
			end else begin
				gps_avg_reg <= NS_W'($signed({2'b00, gps_avg_reg}) + (rel_diff >>> AVG_SHIFT));
			end
		end
	end

	// Cycles since the last arrived pulse per source, saturating
	generate
		for (genvar s = 0; s < 2; s++) begin : g_space
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					space_cnt_reg[s] <= '1;
				end else if (cand_v && cand_src == 1'(s)) begin
					space_cnt_reg[s] <= '0;
				end else if (space_cnt_reg[s] != '1) begin
					space_cnt_reg[s] <= space_cnt_reg[s] + 1'b1;
				end
			end
		end
	endgenerate

	// Rate window of period_reg seconds, limit_reg stores per window
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			win_cnt_reg <= '0;
			win_sec_reg <= '0;
		end else if (stamp_clear || per_second_store_limit_wr || store_period_seconds_wr) begin
			win_cnt_reg <= '0;
			win_sec_reg <= '0;
		end else if (sec_tick && win_sec_reg + 1'b1 >= period_reg) begin
			win_sec_reg <= '0;
			win_cnt_reg <= LIMIT_W'(accept && rate_en);
		end else begin
			win_sec_reg <= sec_tick ? win_sec_reg + 1'b1 : win_sec_reg;
			if (accept && rate_en) begin
				win_cnt_reg <= win_cnt_reg + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Buffer and stamp memory
	// ----------------------------------------------------------------
	logic buf_out_valid;
	logic [ENTRY_W-1:0] buf_out_data;
	logic mem_we;
	logic [ENTRY_W-1:0] mem_reg [MEM_ENTRIES];
	logic [MPW-1:0] wr_ptr_reg;
	logic [6:0] cnt_reg;
	logic [MPW-1:0] rd_phys;

	// Memory writes stall while the host walks the memory
	assign mem_we = buf_out_valid && !mem_hold && !stamp_clear;

	pts_fifo #(
		.WIDTH(ENTRY_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk(clk),
		.rst(rst),
		.flush(stamp_clear),
		.in_valid(accept),
		.in_ready(buf_ready),
		.in_data({cand_src, cand_stamp}),
		.out_valid(buf_out_valid),
		.out_ready(mem_we),
		.out_data(buf_out_data)
	);

	generate
		for (genvar i = 0; i < MEM_ENTRIES; i++) begin : g_mem
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					mem_reg[i] <= '0;
				end else if (stamp_clear) begin
					mem_reg[i] <= '0;
				end else if (mem_we && wr_ptr_reg == MPW'(i)) begin
					mem_reg[i] <= buf_out_data;
				end
			end
		end
	endgenerate

	// Ring overwrites the oldest entry once full
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			cnt_reg <= '0;
		end else if (stamp_clear) begin
			wr_ptr_reg <= '0;
			cnt_reg <= '0;
		end else if (mem_we) begin
			wr_ptr_reg <= mem_step(wr_ptr_reg);
			cnt_reg <= (cnt_reg == MEM_FULL) ? cnt_reg : cnt_reg + 1'b1;
		end
	end

	// Index 0 is the oldest stamp, count-1 the newest
	always_comb begin
		rd_phys = MPW'(mem_rd_idx);
		if (cnt_reg == MEM_FULL) begin
			// Eight bits: pointer plus index can pass 127
			if (8'(wr_ptr_reg) + 8'(mem_rd_idx) >= 8'(MEM_FULL)) begin
				rd_phys = MPW'(8'(wr_ptr_reg) + 8'(mem_rd_idx) - 8'(MEM_FULL));
			end else begin
				rd_phys = MPW'(8'(wr_ptr_reg) + 8'(mem_rd_idx));
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_rd_data <= '0;
			mem_count <= '0;
		end else begin
			mem_rd_data <= (mem_rd_idx < cnt_reg) ? mem_reg[rd_phys] : '0;
			mem_count <= cnt_reg;
		end
	end

	// ----------------------------------------------------------------
	// Last stamp, offsets and status
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			last_stamp <= '0;
			last_stamp_valid <= 1'b0;
			stamp_event <= 1'b0;
			drop_overflow <= 1'b0;
		end else begin
			stamp_event <= accept && mode_reg == PTS_MODE_ASYNC;
			drop_overflow <= cand_v && !buf_ready;
			if (stamp_clear) begin
				last_stamp <= '0;
				last_stamp_valid <= 1'b0;
			end else if (accept) begin
				last_stamp <= {cand_src, cand_stamp};
				last_stamp_valid <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			offset_ext_valid <= 1'b0;
			offset_gps_valid <= 1'b0;
			offset_ext_ns <= '0;
			offset_gps_ns <= '0;
		end else begin
			offset_ext_valid <= accept && cand_src == SRC_EXT && mode_reg == PTS_MODE_OFFSET_REPORT_SELECT
				&& diff_sel_reg != PTS_DIFF_GPS;
			offset_gps_valid <= accept && cand_src == SRC_GPS && mode_reg == PTS_MODE_OFFSET_REPORT_SELECT
				&& diff_sel_reg != PTS_DIFF_EXT;
			if (accept && cand_src == SRC_EXT) begin
				offset_ext_ns <= rel_diff;
			end
			if (accept && cand_src == SRC_GPS) begin
				offset_gps_ns <= gps_sec_off;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode <= PTS_MODE_OFF;
			source <= PTS_SRC_GPS;
			offset_report_select <= PTS_DIFF_EXT;
			filter_set <= FILTER_RESET;
			per_second_store_limit <= LIMIT_MIN;
			store_period_seconds <= PERIOD_MIN;
		end else begin
			mode <= mode_reg;
			source <= source_reg;
			offset_report_select <= diff_sel_reg;
			filter_set <= filter_reg;
			per_second_store_limit <= limit_reg;
			store_period_seconds <= period_reg;
		end
	end
endmodule

// ==== sim/pts_timestamp_filter_monitor.sv ====
// Concurrent checks on the pulse time-stamp filter ports
`timescale 1ns/10ps
module pts_ts_monitor
	import pts_pkg::*;
#(
	parameter int MEM_ENTRIES = 100
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic per_second_store_limit_wr,
	input wire logic [LIMIT_W-1:0] per_second_store_limit_data,
	input wire logic store_period_seconds_wr,
	input wire logic [PERIOD_W-1:0] store_period_seconds_data,
	input wire logic stamp_clear,
	input wire logic [6:0] mem_count,
	input wire logic [1:0] offset_report_select,
	input wire logic [3:0] filter_set,
	input wire logic [LIMIT_W-1:0] per_second_store_limit,
	input wire logic [PERIOD_W-1:0] store_period_seconds,
	input wire logic offset_ext_valid,
	input wire logic offset_gps_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// Write sequences
	// ------------------------------------------------------------
	sequence s_lim_wr;
		per_second_store_limit_wr && per_second_store_limit_data inside {[7'h01:7'h64]};
	endsequence
	sequence s_per_wr;
		store_period_seconds_wr && !per_second_store_limit_wr &&
			store_period_seconds_data inside {[20'h0_0001:20'h9_3A80]};
	endsequence
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	chk_reset_defaults: assert property ($past(rst) |->
		filter_set == 4'h1 && per_second_store_limit == 7'h01 && offset_report_select == 2'h0
		&& store_period_seconds == 20'h0_0001 && mem_count == 7'h00) else $error("bad reset");
	chk_lim_per_one: assert property (s_lim_wr |-> ##2
		store_period_seconds == 20'h0_0001) else $error("period not forced");
	chk_per_lim_one: assert property (s_per_wr |-> ##2
		per_second_store_limit == 7'h01) else $error("limit not forced");
	chk_off_excl: assert property (filter_set[0] |-> filter_set[3:1] == 3'h0)
		else $error("off with others");
	chk_lim_range: assert property (per_second_store_limit inside {[7'h01:7'h64]})
		else $error("limit range");
	chk_mem_max: assert property (mem_count <= 7'(MEM_ENTRIES))
		else $error("memory overfull");
	chk_clear_empty: assert property (stamp_clear |-> ##[1:2] mem_count == 7'h00)
		else $error("clear left entries");
	chk_ext_sel: assert property (offset_ext_valid |-> offset_report_select != 2'h1)
		else $error("ext offset not selected");
	chk_gps_sel: assert property (offset_gps_valid |-> offset_report_select != 2'h0)
		else $error("gps offset not selected");
endmodule
bind pts_timestamp_filter pts_ts_monitor #(.MEM_ENTRIES(MEM_ENTRIES)) u_mon (
	.clk(clk), .rst(rst), .stamp_clear(stamp_clear), .mem_count(mem_count),
	.per_second_store_limit_wr(per_second_store_limit_wr),
	.per_second_store_limit_data(per_second_store_limit_data),
	.store_period_seconds_wr(store_period_seconds_wr),
	.store_period_seconds_data(store_period_seconds_data),
	.offset_report_select(offset_report_select), .filter_set(filter_set),
	.per_second_store_limit(per_second_store_limit), .store_period_seconds(store_period_seconds),
	.offset_ext_valid(offset_ext_valid), .offset_gps_valid(offset_gps_valid));

// ==== sim/pts_pps_model.sv ====
// Model of the GNSS pulse and the external pulse source
`timescale 1ns/10ps
module pts_pps_model (
	input wire logic clk,
	output logic gps_pps,
	output logic ext_pps
);
	// Input idles low, as its pull-down leaves it
	initial begin
		gps_pps = 1'b0;
		ext_pps = 1'b0;
	end
	task automatic fire(input logic external_pulse_source, input int hi);
		@(negedge clk);
		if (external_pulse_source) ext_pps = 1'b1; else gps_pps = 1'b1;
		repeat (hi) @(negedge clk);
		if (external_pulse_source) ext_pps = 1'b0; else gps_pps = 1'b0;
	endtask
endmodule

// ==== sim/pts_timestamp_filter_test.sv ====
// Self-checking bench for the pulse time-stamp filter
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
	$display("ERROR %0t: got %0h want %0h", $time, (a), (b)); end end
module pts_timestamp_filter_test import pts_pkg::*;;
	logic clk, rst, gps_pps, ext_pps, time_load, mode_wr, source_wr, offset_report_select_wr;
	logic filter_wr, per_second_store_limit_wr, store_period_seconds_wr, ext_edge_falling;
	logic stamp_clear, mem_hold, last_stamp_valid, stamp_event, offset_ext_valid, e, ovf, og, oe;
	logic offset_gps_valid, drop_overflow;
	logic [WEEK_W-1:0] time_load_week, wk;
	logic [SEC_W-1:0] time_load_sec;
	logic [2:0] mode_data, mode;
	logic [1:0] source_data, offset_report_select_data, source, offset_report_select;
	logic [3:0] filter_data, filter_set;
	logic [LIMIT_W-1:0] per_second_store_limit_data, per_second_store_limit;
	logic [PERIOD_W-1:0] store_period_seconds_data, store_period_seconds;
	logic [6:0] mem_rd_idx, mem_count;
	logic [ENTRY_W-1:0] mem_rd_data, last_stamp;
	logic signed [31:0] offset_ext_ns, offset_gps_ns;
	int error_cnt, tests_run, stored;
	logic exp_q[$];
	pts_pps_model src (.clk(clk), .gps_pps(gps_pps), .ext_pps(ext_pps));
	pts_timestamp_filter dut (.clk(clk), .rst(rst), .gps_pps(gps_pps), .ext_pps(ext_pps),
		.time_load(time_load), .time_load_week(time_load_week), .time_load_sec(time_load_sec),
		.mode_wr(mode_wr), .mode_data(mode_data), .source_wr(source_wr),
		.source_data(source_data), .offset_report_select_wr(offset_report_select_wr),
		.offset_report_select_data(offset_report_select_data), .filter_wr(filter_wr),
		.filter_data(filter_data), .per_second_store_limit_wr(per_second_store_limit_wr),
		.per_second_store_limit_data(per_second_store_limit_data),
		.store_period_seconds_wr(store_period_seconds_wr),
		.store_period_seconds_data(store_period_seconds_data),
		.ext_edge_falling(ext_edge_falling), .stamp_clear(stamp_clear), .mem_hold(mem_hold),
		.mem_rd_idx(mem_rd_idx), .mem_rd_data(mem_rd_data), .mem_count(mem_count),
		.mode(mode), .source(source), .offset_report_select(offset_report_select),
		.filter_set(filter_set), .per_second_store_limit(per_second_store_limit),
		.store_period_seconds(store_period_seconds), .last_stamp(last_stamp),
		.last_stamp_valid(last_stamp_valid), .stamp_event(stamp_event),
		.offset_ext_valid(offset_ext_valid), .offset_gps_valid(offset_gps_valid),
		.offset_ext_ns(offset_ext_ns), .offset_gps_ns(offset_gps_ns),
		.drop_overflow(drop_overflow));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic summarize();
		if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Kinds: 0 mode 1 source 2 offset 3 filter 4 limit 5 period 6 clear 7 time
	task automatic wr(input int k, input int v);
		@(negedge clk);
		case (k)
			0: begin mode_wr = 1'b1; mode_data = 3'(v); end
			1: begin source_wr = 1'b1; source_data = 2'(v); end
			2: begin offset_report_select_wr = 1'b1; offset_report_select_data = 2'(v); end
			3: begin filter_wr = 1'b1; filter_data = 4'(v); end
			4: begin per_second_store_limit_wr = 1'b1; per_second_store_limit_data = 7'(v); end
			5: begin store_period_seconds_wr = 1'b1; store_period_seconds_data = 20'(v); end
			6: stamp_clear = 1'b1;
			default: begin time_load = 1'b1; time_load_week = 16'(v); end
		endcase
		@(negedge clk);
		{mode_wr, source_wr, offset_report_select_wr, filter_wr, per_second_store_limit_wr,
			store_period_seconds_wr, stamp_clear, time_load} = '0;
		// Status outputs trail a write by two edges
		repeat (2) @(negedge clk);
	endtask
	task automatic pulse(input logic external_pulse_source, input int gap, input logic keep);
		if (keep) exp_q.push_back(external_pulse_source);
		if (keep) stored++;
		src.fire(external_pulse_source, 1);
		repeat (gap) @(negedge clk);
	endtask
	// ------------------------------------------------------------
	// Clock, watchdog and result checker
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	always @(negedge clk) begin
		if (drop_overflow === 1'b1) ovf = 1'b1;
		if (offset_gps_valid === 1'b1) og = 1'b1;
		if (offset_ext_valid === 1'b1) oe = 1'b1;
		if (stamp_event === 1'b1) begin
			`CHK(exp_q.size() > 0, 1'b1)
			if (exp_q.size() > 0) e = exp_q.pop_front();
			`CHK(last_stamp[ENTRY_W-1], e)
			`CHK(last_stamp[ENTRY_W-2 -: WEEK_W], wk)
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{time_load, mode_wr, source_wr, offset_report_select_wr, filter_wr, stamp_clear} = '0;
		{per_second_store_limit_wr, store_period_seconds_wr, ext_edge_falling, mem_hold} = '0;
		{time_load_week, time_load_sec, mode_data, source_data, filter_data} = '0;
		{offset_report_select_data, per_second_store_limit_data, mem_rd_idx} = '0;
		store_period_seconds_data = '0;
		{ovf, og, oe} = '0;
		rst = 1'b1;
		void'($urandom(6344));
		repeat (3) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		`CHK({filter_set, source, offset_report_select}, 8'h10)
		wk = 16'($urandom());
		wr(7, wk);
		wr(0, 1);
		pulse(0, 8, 1);
		pulse(1, 8, 0);
		wr(1, 2);
		pulse(1, 8, 1);
		ext_edge_falling = 1'b1;
		pulse(1, 8, 1);
		ext_edge_falling = 1'b0;
		wr(3, 'h4);
		pulse(1, 0, 1);
		pulse(0, 0, 1);
		pulse(1, 8, 0);
		wr(6, 1);
		`CHK({mem_count, last_stamp_valid, last_stamp}, '0)
		stored = 0;
		wr(1, 1);
		wr(3, 'h2);
		pulse(0, 0, 1);
		pulse(1, 8, 1);
		pulse(1, 8, 0);
		`CHK(offset_ext_ns, 32'(2 * CLK_NS))
		wr(3, 'h8);
		wr(5, 2);
		wr(4, 3);
		`CHK({per_second_store_limit, store_period_seconds}, {7'h03, 20'h0_0001})
		for (int i = 0; i < 5; i++) pulse(1, 8, i < 3);
		wr(5, 2);
		`CHK({per_second_store_limit, store_period_seconds}, {7'h01, 20'h0_0002})
		wr(4, 'h65);
		`CHK(per_second_store_limit, 7'h01)
		pulse(1, 8, 1);
		pulse(1, 8, 0);
		`CHK(mem_count, 7'(stored))
		`CHK(mem_rd_data[ENTRY_W-1], 1'b0)
		wr(0, 2);
		wr(3, 1);
		mem_hold = 1'b1;
		for (int i = 0; i < 10; i++) pulse(1, 6, 1'b0);
		mem_hold = 1'b0;
		repeat (20) @(negedge clk);
		`CHK({ovf, mem_count}, {1'b1, 7'(stored + 8)})
		wr(2, 1);
		wr(0, 4);
		`CHK({mode, source, offset_report_select}, {3'h4, 2'h2, 2'h1})
		pulse(0, 3, 0);
		`CHK(offset_gps_ns, 32'(last_stamp[NS_W-1:0]))
		pulse(1, 8, 0);
		`CHK({og, oe}, 2'h2)
		wr(2, 0);
		pulse(1, 8, 0);
		`CHK({oe, last_stamp_valid}, 2'h3)
		`CHK(exp_q.size(), 0)
		summarize();
	end
endmodule
